// [rtl/camera_output_line_mux.sv]
// Output line selector for the opto-isolated output and the open-collector line,
// with debounced inputs, camera state sources and the two link lamps.
// Assumes camera events, timer, logic block and link status come from logic on clk.
`timescale 1ns/100ps
module camera_output_line_mux
   import cam_line_pkg::*;
#(
   parameter int unsigned PPS_CYC = PPS_HALF_CYC,
   parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
   parameter int unsigned ACT_CYC = ACT_HOLD_CYC
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Camera sources on clk.
   input wire cam_events_t events,
   input wire logic sensor_frame_valid,
   input wire logic timer0_active,
   input wire logic logic_block0,
   // Link status.
   input wire link_state_t link,
   // Pins.
   input wire logic opto_input_line,
   output logic opto_output_line,
   input wire logic bidir_oc_line_in,
   output logic bidir_oc_line_out,
   output logic bidir_oc_line_oe,
   // Lamps.
   output logic led_speed,
   output logic led_activity
);

   localparam logic [31:0] ACT_LOAD = 32'(ACT_CYC);

   // ************************************************************
   // Helper functions.
   // ************************************************************

   // Picks the selected source; unused codes give low.
   function automatic logic src_mux(input src_t sel, input logic [14:0] vec);
      logic bit_out;
      bit_out = 1'b0;
      if (sel <= SRC_PPS) begin
         bit_out = vec[sel];
      end
      return bit_out;
   endfunction

   // Accepts only defined source codes from a write.
   function automatic src_t src_check(input logic [3:0] val, input src_t old);
      src_t res;
      res = old;
      if (val <= 4'hE) begin
         res = src_t'(val);
      end
      return res;
   endfunction

   // ************************************************************
   // Sub-blocks.
   // ************************************************************
   mux_state_t s_ff, nxt_s;
   logic deb_opto;
   logic deb_bidir;
   logic pps_wave;
   logic blink_wave;
   logic [14:0] src_vec;

   line_debounce u_deb_opto (
      .clk(clk),
      .rst(rst),
      .pin(opto_input_line),
      .deb_time(s_ff.deb_time),
      .filt(deb_opto)
   );

   line_debounce u_deb_bidir (
      .clk(clk),
      .rst(rst),
      .pin(bidir_oc_line_in),
      .deb_time(s_ff.deb_time),
      .filt(deb_bidir)
   );

   square_wave #(.HALF_CYC(PPS_CYC)) u_pps (
      .clk(clk),
      .rst(rst),
      .run(1'b1),
      .wave(pps_wave)
   );

   square_wave #(.HALF_CYC(BLINK_CYC)) u_blink (
      .clk(clk),
      .rst(rst),
      .run(s_ff.act_cnt != 32'h0000_0000),
      .wave(blink_wave)
   );

   // ************************************************************
   // Source vector, indexed by source code.
   // ************************************************************
   always_comb begin
      src_vec = '0;
      src_vec[SRC_FRAME_WAIT] = s_ff.frame_wait;
      src_vec[SRC_FRAME_TRIG] = s_ff.trig_pipe[TRIG_DLY_CYC-1];
      src_vec[SRC_EXPOSURE] = s_ff.exposing;
      src_vec[SRC_ACQ_WAIT] = s_ff.acq_wait;
      src_vec[SRC_ACQ_TRIG] = s_ff.acq_pulse;
      src_vec[SRC_READOUT] = sensor_frame_valid;
      src_vec[SRC_DEB_OPTO] = deb_opto;
      src_vec[SRC_DEB_BIDIR] = deb_bidir;
      src_vec[SRC_USER1] = s_ff.ctrl[CTRL_USER1];
      src_vec[SRC_USER2] = s_ff.ctrl[CTRL_USER2];
      src_vec[SRC_TIMER0] = timer0_active;
      src_vec[SRC_SW0] = s_ff.ctrl[CTRL_SW0];
      src_vec[SRC_SW1] = s_ff.ctrl[CTRL_SW1];
      src_vec[SRC_LOGIC0] = logic_block0;
      src_vec[SRC_PPS] = pps_wave;
   end

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      nxt_s = s_ff;
      // Configuration writes.
      if (wr) begin
         case (addr)
            ADDR_SEL_OPTO: begin
               nxt_s.sel_opto = src_check(wdata[3:0], s_ff.sel_opto);
            end
            ADDR_SEL_BIDIR: begin
               nxt_s.sel_bidir = src_check(wdata[3:0], s_ff.sel_bidir);
            end
            ADDR_CTRL: begin
               nxt_s.ctrl = wdata[4:0];
            end
            ADDR_DEB_TIME: begin
               nxt_s.deb_time = wdata[15:0];
            end
            default: begin
               nxt_s.ctrl = s_ff.ctrl;
            end
         endcase
      end
      // Register reads answer in the next cycle; unmapped reads give zero.
      nxt_s.rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            ADDR_SEL_OPTO: nxt_s.rdata = {28'h0000000, s_ff.sel_opto};
            ADDR_SEL_BIDIR: nxt_s.rdata = {28'h0000000, s_ff.sel_bidir};
            ADDR_CTRL: nxt_s.rdata = {27'h0000000, s_ff.ctrl};
            ADDR_DEB_TIME: nxt_s.rdata = {16'h0000, s_ff.deb_time};
            ADDR_STATUS: begin
               nxt_s.rdata = {22'h000000, pps_wave, s_ff.led_act, s_ff.led_speed,
                  s_ff.acq_wait, s_ff.exposing, s_ff.frame_wait, deb_bidir, deb_opto,
                  s_ff.bidir_oe, s_ff.opto_out};
            end
            default: nxt_s.rdata = 32'h0000_0000;
         endcase
      end
      // Frame wait falls at exposure start and rises once the image is out.
      if (events.exposure_start) begin
         nxt_s.frame_wait = 1'b0;
      end else if (events.frame_out_done) begin
         nxt_s.frame_wait = 1'b1;
      end
      // Exposure level follows the exposure start and end events.
      if (events.exposure_start) begin
         nxt_s.exposing = 1'b1;
      end else if (events.exposure_end) begin
         nxt_s.exposing = 1'b0;
      end
      // Acquisition wait is low for the whole transfer.
      if (events.transfer_start) begin
         nxt_s.acq_wait = 1'b0;
      end else if (events.transfer_done) begin
         nxt_s.acq_wait = 1'b1;
      end
      nxt_s.acq_pulse = events.transfer_start;
      // The trigger path models the internal processing delay.
      nxt_s.trig_pipe = {s_ff.trig_pipe[TRIG_DLY_CYC-2:0], deb_opto};
      // Registered line outputs keep glitches off the pins.
      nxt_s.opto_out = src_mux(s_ff.sel_opto, src_vec);
      // Open collector pulls low only when configured as an output.
      nxt_s.bidir_oe = s_ff.ctrl[CTRL_BIDIR_OUT] && !src_mux(s_ff.sel_bidir, src_vec);
      // Lamps: speed from link rate, activity blinks until the hold time after the last traffic runs out.
      nxt_s.led_speed = link.link_up && link.gigabit;
      if (link.link_up && link.activity) begin
         nxt_s.act_cnt = ACT_LOAD;
      end else if (!link.link_up) begin
         nxt_s.act_cnt = 32'h0000_0000;
      end else if (s_ff.act_cnt != 32'h0000_0000) begin
         nxt_s.act_cnt = s_ff.act_cnt - 32'h0000_0001;
      end
      nxt_s.led_act = (s_ff.act_cnt != 32'h0000_0000) && !blink_wave;
   end

   // ************************************************************
   // State register.
   // ************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
         s_ff.sel_opto <= SRC_RST;
         s_ff.sel_bidir <= SRC_RST;
         s_ff.ctrl <= CTRL_RST;
         s_ff.deb_time <= DEB_TIME_RST;
         s_ff.frame_wait <= 1'b1;
         s_ff.acq_wait <= 1'b1;
         s_ff.opto_out <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the state register; the open-collector data is low.
   assign rdata = s_ff.rdata;
   assign opto_output_line = s_ff.opto_out;
   assign bidir_oc_line_out = 1'b0;
   assign bidir_oc_line_oe = s_ff.bidir_oe;
   assign led_speed = s_ff.led_speed;
   assign led_activity = s_ff.led_act;

   // ************************************************************
   // Assertions.
   // ************************************************************
   // Every check below runs on clk and rests during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // A transfer start followed by a quiet cycle.
   sequence seq_xfer_start;
      events.transfer_start ##1 !events.transfer_start;
   endsequence

   // Frame wait drops right after exposure starts.
   a_frame_wait_low: assert property (
      events.exposure_start |=> !s_ff.frame_wait)
      else $error("Frame wait not low after exposure start.");

   // The internal trigger trails the debounced input by the pipe depth.
   a_trig_delay: assert property (
      s_ff.trig_pipe[TRIG_DLY_CYC-1] == $past(deb_opto, 4))
      else $error("Internal trigger does not repeat the input after the delay.");

   // Exposure level holds until the end event arrives.
   a_exposure_span: assert property (
      (events.exposure_start || s_ff.exposing) && !events.exposure_end |=> s_ff.exposing)
      else $error("Exposure active dropped before exposure end.");

   // An end event without a start clears the level.
   a_exposure_end: assert property (
      events.exposure_end && !events.exposure_start |=> !s_ff.exposing)
      else $error("Exposure active still high after exposure end.");

   // Acquisition wait drops right after a transfer starts.
   a_acq_wait_low: assert property (
      events.transfer_start |=> !s_ff.acq_wait)
      else $error("Acquisition wait not low during transfer.");

   // The transfer mark lasts exactly one cycle.
   a_acq_pulse: assert property (
      seq_xfer_start |-> s_ff.acq_pulse ##1 !s_ff.acq_pulse)
      else $error("Transfer start mark is not a single cycle.");

   // A held user level reaches the opto line.
   a_user_level: assert property (
      s_ff.sel_opto == SRC_USER1 && $stable(s_ff.sel_opto) && $stable(s_ff.ctrl)
      |=> opto_output_line == $past(s_ff.ctrl[CTRL_USER1]))
      else $error("Opto output does not follow user level one.");

   // Speed lamp follows the link rate one cycle late.
   a_speed_lamp: assert property (
      ##1 led_speed == $past(link.link_up && link.gigabit))
      else $error("Speed lamp does not follow link rate.");

   // No hold time left means a dark activity lamp.
   a_idle_dark: assert property (
      s_ff.act_cnt == 32'h0000_0000 |=> !led_activity)
      else $error("Activity lamp lit while link idle.");

   // A link that goes down darkens the activity lamp.
   a_link_down_dark: assert property (
      !link.link_up |-> ##2 !led_activity)
      else $error("Activity lamp lit after link down.");

   // An input-mode line is never pulled low.
   a_input_quiet: assert property (
      !s_ff.ctrl[CTRL_BIDIR_OUT] |=> !bidir_oc_line_oe)
      else $error("Open-collector line driven while set as input.");

   // A selector write is seen on the line two edges later.
   a_sel_next_cycle: assert property (
      wr && addr == ADDR_SEL_OPTO && wdata[3:0] == 4'h8 ##1 !wr
      |=> opto_output_line == $past(s_ff.ctrl[CTRL_USER1]))
      else $error("Selection change did not reach the line in time.");

   // The unused selector code leaves the selection alone.
   a_sel_refused: assert property (
      wr && addr == ADDR_SEL_OPTO && wdata[3:0] == 4'hF
      |=> $stable(s_ff.sel_opto))
      else $error("Unused selector code changed the selection.");

   // Frame valid reaches the opto line one stage later.
   a_readout_pass: assert property (
      s_ff.sel_opto == SRC_READOUT
      |=> opto_output_line == $past(sensor_frame_valid))
      else $error("Frame valid not seen on the opto line.");

   // The debounced input reaches the opto line one stage later.
   a_deb_source: assert property (
      s_ff.sel_opto == SRC_DEB_OPTO
      |=> opto_output_line == $past(deb_opto))
      else $error("Debounced input not seen on the opto line.");

   // The timer channel reaches the opto line one stage later.
   a_timer_pass: assert property (
      s_ff.sel_opto == SRC_TIMER0
      |=> opto_output_line == $past(timer0_active))
      else $error("Timer level not seen on the opto line.");

   // Software signal zero reaches the opto line one stage later.
   a_sw_level: assert property (
      s_ff.sel_opto == SRC_SW0
      |=> opto_output_line == $past(s_ff.ctrl[CTRL_SW0]))
      else $error("Software level not seen on the opto line.");

   // The logic block result reaches the opto line one stage later.
   a_logic_pass: assert property (
      s_ff.sel_opto == SRC_LOGIC0
      |=> opto_output_line == $past(logic_block0))
      else $error("Logic block result not seen on the opto line.");

endmodule

// [rtl/cam_line_pkg.sv]
// Constants, types and carriers shared by the camera output line selector.
// Assumes one 200 MHz system clock and an active-high asynchronous reset.
package cam_line_pkg;

   // ************************************************************
   // Clock and timing.
   // ************************************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned PPS_PERIOD_MS = 1000;
   localparam int unsigned BLINK_PERIOD_MS = 100;
   localparam int unsigned ACT_HOLD_MS = 50;
   localparam int unsigned PPS_HALF_CYC = (CLK_HZ / 1000) * PPS_PERIOD_MS / 2;
   localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
   localparam int unsigned ACT_HOLD_CYC = (CLK_HZ / 1000) * ACT_HOLD_MS;
   localparam int unsigned TRIG_DLY_CYC = 4;
   localparam logic [15:0] DEB_TIME_RST = 16'h0190;

   // ************************************************************
   // Register map, byte addresses on the plain register port.
   // ************************************************************
   localparam logic [7:0] ADDR_SEL_OPTO = 8'h00;
   localparam logic [7:0] ADDR_SEL_BIDIR = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_DEB_TIME = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam int unsigned CTRL_USER1 = 0;
   localparam int unsigned CTRL_USER2 = 1;
   localparam int unsigned CTRL_SW0 = 2;
   localparam int unsigned CTRL_SW1 = 3;
   localparam int unsigned CTRL_BIDIR_OUT = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;

   // Source codes of the output line selectors.
   typedef enum logic [3:0] {
      SRC_FRAME_WAIT = 4'h0, SRC_FRAME_TRIG = 4'h1, SRC_EXPOSURE = 4'h2,
      SRC_ACQ_WAIT = 4'h3, SRC_ACQ_TRIG = 4'h4, SRC_READOUT = 4'h5,
      SRC_DEB_OPTO = 4'h6, SRC_DEB_BIDIR = 4'h7, SRC_USER1 = 4'h8,
      SRC_USER2 = 4'h9, SRC_TIMER0 = 4'hA, SRC_SW0 = 4'hB,
      SRC_SW1 = 4'hC, SRC_LOGIC0 = 4'hD, SRC_PPS = 4'hE
   } src_t;
   localparam src_t SRC_RST = SRC_FRAME_WAIT;

   // ************************************************************
   // Carriers.
   // ************************************************************
   typedef struct packed {
      logic exposure_start;
      logic exposure_end;
      logic frame_out_done;
      logic transfer_start;
      logic transfer_done;
   } cam_events_t;

   typedef struct packed {
      logic link_up;
      logic gigabit;
      logic activity;
   } link_state_t;

   typedef struct packed {
      logic [2:0] sync;
      logic [15:0] cnt;
      logic filt;
   } deb_state_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic wave;
   } sqw_state_t;

   typedef struct packed {
      src_t sel_opto;
      src_t sel_bidir;
      logic [4:0] ctrl;
      logic [15:0] deb_time;
      logic frame_wait;
      logic exposing;
      logic acq_wait;
      logic acq_pulse;
      logic [TRIG_DLY_CYC-1:0] trig_pipe;
      logic opto_out;
      logic bidir_oe;
      logic led_speed;
      logic led_act;
      logic [31:0] act_cnt;
      logic [31:0] rdata;
   } mux_state_t;

endpackage

// [rtl/line_debounce.sv]
// Synchroniser and debounce filter for one input pin.
// Assumes the pin is asynchronous to clk; the time is given in clock cycles.
`timescale 1ns/100ps
module line_debounce
   import cam_line_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Pin and setting.
   input wire logic pin,
   input wire logic [15:0] deb_time,
   // Filtered level.
   output logic filt
);

   deb_state_t s_ff, nxt_s;

   // A level is accepted once the 2nd and 3rd stages agree and it has stood long enough.
   always_comb begin
      nxt_s = s_ff;
      nxt_s.sync = {s_ff.sync[1:0], pin};
      if ((s_ff.sync[1] == s_ff.sync[2]) && (s_ff.sync[2] != s_ff.filt)) begin
         if (s_ff.cnt >= deb_time) begin
            nxt_s.filt = s_ff.sync[2];
            nxt_s.cnt = 16'h0000;
         end else begin
            nxt_s.cnt = s_ff.cnt + 16'h0001;
         end
      end else begin
         nxt_s.cnt = 16'h0000;
      end
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign filt = s_ff.filt;

   a_deb_change_late: assert property (
      @(posedge clk) disable iff (rst)
      $changed(s_ff.filt) |-> $past(s_ff.cnt) >= $past(deb_time))
      else $error("Filtered level changed before the debounce time.");

endmodule

// [rtl/square_wave.sv]
// Free-running square wave of a set half period, held low while not running.
// Assumes HALF_CYC is at least 2 clock cycles.
`timescale 1ns/100ps
module square_wave
   import cam_line_pkg::*;
#(
   parameter int unsigned HALF_CYC = PPS_HALF_CYC
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Control and wave.
   input wire logic run,
   output logic wave
);

   localparam logic [31:0] LAST = 32'(HALF_CYC - 1);

   sqw_state_t s_ff, nxt_s;

   // Toggle each half period; equal halves give half duty.
   always_comb begin
      nxt_s = s_ff;
      if (!run) begin
         nxt_s = '0;
      end else if (s_ff.cnt >= LAST) begin
         nxt_s.cnt = 32'h0000_0000;
         nxt_s.wave = ~s_ff.wave;
      end else begin
         nxt_s.cnt = s_ff.cnt + 32'h0000_0001;
      end
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign wave = s_ff.wave;

endmodule

// [sim/line_wiring.sv]
// Outside wiring of the camera I/O connector: pull-up on the open-collector
// line, an external switch that may pull it low, and the opto input driver.
// Assumes the bench sets ext_low and opto_drive after rising clock edges.
`timescale 1ns/100ps
module line_wiring (
   // Device side of the open-collector line.
   input wire logic bidir_out,
   input wire logic bidir_oe,
   // Outside drivers.
   input wire logic ext_low,
   input wire logic opto_drive,
   // Pin levels.
   output logic bidir_level,
   output logic opto_pin
);
   // The pull-up holds the line high unless the device or the switch pulls it low.
   assign bidir_level = (bidir_oe ? bidir_out : 1'b1) & ~ext_low;
   // The opto input follows the outside driver.
   assign opto_pin = opto_drive;
endmodule

// [sim/camera_output_line_mux_bench.sv]
// Self-checking bench of the output line selector with its outside wiring.
// Assumes shortened timing parameters and a 200 MHz clock.
`timescale 1ns/100ps
module camera_output_line_mux_bench;
   import cam_line_pkg::*;
   // ************************************************************
   // Signals.
   // ************************************************************
   logic clk, rst, wr, rd, sensor_frame_valid, timer0_active, logic_block0;
   logic ext_low, opto_drive, opto_pin, bidir_level;
   logic opto_output_line, bidir_oc_line_out, bidir_oc_line_oe, led_speed, led_activity;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   cam_events_t events;
   link_state_t link;
   int n_errors, n_checks, n;
   camera_output_line_mux #(.PPS_CYC(10), .BLINK_CYC(4), .ACT_CYC(40)) dut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .events(events), .sensor_frame_valid(sensor_frame_valid),
      .timer0_active(timer0_active), .logic_block0(logic_block0), .link(link),
      .opto_input_line(opto_pin), .opto_output_line(opto_output_line),
      .bidir_oc_line_in(bidir_level), .bidir_oc_line_out(bidir_oc_line_out),
      .bidir_oc_line_oe(bidir_oc_line_oe), .led_speed(led_speed), .led_activity(led_activity));
   line_wiring wiring (.bidir_out(bidir_oc_line_out), .bidir_oe(bidir_oc_line_oe),
      .ext_low(ext_low), .opto_drive(opto_drive), .bidir_level(bidir_level), .opto_pin(opto_pin));
   // Free-running 5 ns clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ************************************************************
   // Shared tasks.
   // ************************************************************
   // Prints the counts and the verdict, then ends the run.
   task conclude;
      $display("Mismatches %0d of %0d checks.", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Compares one value and counts the outcome.
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One write cycle; a clock edge always passes before the strobe rises.
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One read cycle; data are taken in the single cycle after the strobe.
   task rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   // Lets a registered change reach the pins.
   task settle;
      repeat (3) @(negedge clk);
   endtask
   // Counts cycles until the opto output shows a level, with a bound.
   task wait_out(input logic v, input int lim, output int c);
      c = 0;
      while (opto_output_line !== v) begin
         @(negedge clk);
         c++;
         if (c > lim) begin
            n_errors++;
            $display("Error opto output wait expected %h seen %h", v, opto_output_line);
            conclude();
         end
      end
   endtask
   // Sends one event pulse.
   task pulse(input cam_events_t e);
      @(posedge clk);
      events <= e;
      @(posedge clk);
      events <= '0;
   endtask
   // Counts high cycles of the opto output over a span.
   task count_high(input int span, output int c);
      c = 0;
      repeat (span) begin
         @(negedge clk);
         if (opto_output_line === 1'b1) c++;
      end
   endtask
   // ************************************************************
   // Scenarios.
   // ************************************************************
   // Reset values, unmapped read and idle pins.
   task t_reset;
      rd_reg(ADDR_DEB_TIME, d); chk("debounce time", {16'h0000, DEB_TIME_RST}, d);
      rd_reg(ADDR_SEL_OPTO, d); chk("opto selector", 32'h00000000, d);
      rd_reg(ADDR_SEL_BIDIR, d); chk("bidir selector", 32'h00000000, d);
      rd_reg(8'h14, d); chk("unmapped read", 32'h00000000, d);
      rd_reg(ADDR_STATUS, d); chk("status", 32'h00000011, d & 32'h00000013);
      chk("opto output", 32'h1, opto_output_line);
      chk("bidir oe", 32'h0, bidir_oc_line_oe);
      chk("bidir data", 32'h0, bidir_oc_line_out);
   endtask
   // Static level sources at both levels, selection timing and the refused code.
   task t_static;
      logic [3:0] codes [6];
      codes = '{4'h8, 4'hB, 4'hC, 4'hA, 4'hD, 4'h5};
      for (int v = 0; v < 2; v++) begin
         wr_reg(ADDR_CTRL, v ? 32'h0000000F : 32'h00000000);
         timer0_active <= v[0]; logic_block0 <= v[0]; sensor_frame_valid <= v[0];
         foreach (codes[i]) begin
            wr_reg(ADDR_SEL_OPTO, {28'h0, codes[i]});
            settle();
            chk("selected source", v, opto_output_line);
         end
      end
      @(posedge clk); sensor_frame_valid <= 1'b0;
      settle();
      wr_reg(ADDR_SEL_OPTO, 32'h00000008);
      @(negedge clk); chk("select latency", 32'h0, opto_output_line);
      @(negedge clk); chk("select latency", 32'h1, opto_output_line);
      @(negedge clk); chk("select latency", 32'h1, opto_output_line);
      wr_reg(ADDR_SEL_OPTO, 32'h0000000F);
      rd_reg(ADDR_SEL_OPTO, d); chk("refused code", 32'h00000008, d);
   endtask
   // Exposure and transfer state sources.
   task t_events;
      wr_reg(ADDR_SEL_OPTO, 32'h0);
      pulse(5'h10); settle(); chk("frame wait", 32'h0, opto_output_line);
      wr_reg(ADDR_SEL_OPTO, 32'h2); settle(); chk("exposing", 32'h1, opto_output_line);
      pulse(5'h08); settle(); chk("exposing", 32'h0, opto_output_line);
      wr_reg(ADDR_SEL_OPTO, 32'h0); settle(); chk("frame wait", 32'h0, opto_output_line);
      pulse(5'h04); settle(); chk("frame wait", 32'h1, opto_output_line);
      wr_reg(ADDR_SEL_OPTO, 32'h3);
      pulse(5'h02); settle(); chk("acq wait", 32'h0, opto_output_line);
      pulse(5'h01); settle(); chk("acq wait", 32'h1, opto_output_line);
      wr_reg(ADDR_SEL_OPTO, 32'h4); settle();
      pulse(5'h02); count_high(8, n); chk("acq mark cycles", 32'd1, n);
   endtask
   // Debounce of both inputs, trigger delay and line direction.
   task t_inputs;
      wr_reg(ADDR_DEB_TIME, 32'h00000008);
      wr_reg(ADDR_SEL_OPTO, 32'h6);
      wr_reg(ADDR_SEL_BIDIR, 32'h1);
      wr_reg(ADDR_CTRL, 32'h00000010); settle();
      chk("bidir pulled low", 32'h0, bidir_level);
      @(posedge clk); opto_drive <= 1'b1;
      repeat (4) @(posedge clk);
      opto_drive <= 1'b0;
      count_high(30, n); chk("short pulse", 32'd0, n);
      @(posedge clk); opto_drive <= 1'b1;
      wait_out(1'b1, 40, n);
      n = 0;
      while (bidir_level !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("trigger delay", TRIG_DLY_CYC, n);
      @(posedge clk); opto_drive <= 1'b0;
      wait_out(1'b0, 40, n);
      wr_reg(ADDR_CTRL, 32'h0);
      wr_reg(ADDR_SEL_OPTO, 32'h7);
      wait_out(1'b1, 40, n);
      @(posedge clk); ext_low <= 1'b1;
      wait_out(1'b0, 40, n);
      chk("bidir as input", 32'h0, bidir_oc_line_oe);
      @(posedge clk); ext_low <= 1'b0;
      wr_reg(ADDR_SEL_BIDIR, 32'h9);
      wr_reg(ADDR_CTRL, 32'h00000010); settle();
      chk("user2 low", 32'h0, bidir_level);
      wr_reg(ADDR_CTRL, 32'h00000012); settle();
      chk("user2 high", 32'h1, bidir_level);
      wr_reg(ADDR_CTRL, 32'h00000000); settle();
      chk("input mode oe", 32'h0, bidir_oc_line_oe);
   endtask
   // Pulse per second half periods.
   task t_pps;
      wr_reg(ADDR_SEL_OPTO, 32'hE); settle();
      wait_out(1'b0, 40, n);
      wait_out(1'b1, 40, n);
      wait_out(1'b0, 40, n); chk("pps high", 32'd10, n);
      wait_out(1'b1, 40, n); chk("pps low", 32'd10, n);
   endtask
   // Link lamps.
   task t_lamps;
      @(posedge clk); link <= '{link_up: 1'b1, gigabit: 1'b1, activity: 1'b0};
      settle(); chk("speed lamp", 32'h1, led_speed);
      n = 0;
      repeat (20) @(negedge clk) if (led_activity !== 1'b0) n++;
      chk("idle activity", 32'd0, n);
      @(posedge clk); link.activity <= 1'b1;
      @(posedge clk); link.activity <= 1'b0;
      n = 0;
      repeat (30) @(negedge clk) if (led_activity === 1'b1) n++;
      chk("blinking", 32'h1, (n > 0 && n < 30));
      repeat (40) @(negedge clk);
      n = 0;
      repeat (20) @(negedge clk) if (led_activity !== 1'b0) n++;
      chk("activity expired", 32'd0, n);
      @(posedge clk); link.gigabit <= 1'b0;
      settle(); chk("speed lamp", 32'h0, led_speed);
   endtask
   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
      events = '0; link = '0; sensor_frame_valid = 1'b0; timer0_active = 1'b0;
      logic_block0 = 1'b0; ext_low = 1'b0; opto_drive = 1'b0;
      n_errors = 0; n_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_static();
      t_events();
      t_inputs();
      t_pps();
      t_lamps();
      conclude();
   end
endmodule
